// file: design/pcs_pkg.sv
// package: constants and types for the pc sequencer and sleep control
package pcs_pkg;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] ADDR_PC_LOW = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_PC_FULL = 8'h10;
    localparam logic [7:0] ADDR_ID_BASE = 8'h20;
    localparam logic [7:0] ADDR_PROG_BASE = 8'h40;
    // flags register field positions
    localparam int FLG_PD_BIT = 3;
    localparam int FLG_TO_BIT = 4;
    localparam int FLG_PAGE_LO = 5;
    localparam int FLG_PAGE_HI = 6;
    // ctrl register fields
    localparam int CTL_WDT_EN_BIT = 0;
    localparam int CTL_CP_BIT = 1;
    localparam int CTL_PROG_BIT = 2;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h18;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [11:0] ID_RST = 12'hfff;
    // instruction classes from the decoder
    typedef enum logic [2:0] {
        PCS_OP_NONE = 3'b000,
        PCS_OP_JUMP = 3'b001,
        PCS_OP_CALL = 3'b010,
        PCS_OP_PCL_WRITE = 3'b011,
        PCS_OP_SLEEP = 3'b100,
        PCS_OP_CLRWDT = 3'b101
    } pcs_op_e;
    // reset-delay timer timing
    localparam int DRT_MS = 18;
    localparam int CLK_MHZ = 100;
    localparam int DRT_CYCLES = DRT_MS * 1000 * CLK_MHZ;
    // id word count
    localparam int ID_WORDS = 4;
endpackage : pcs_pkg

// file: design/pcs_mem_if.sv
// interface: little memory port between core and id store
`timescale 1ns/100ps
`default_nettype none
interface pcs_mem_if #(parameter int AW = 2, parameter int DW = 12);
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport master (output we, output addr, output wdata, input rdata);
    modport slave (input we, input addr, input wdata, output rdata);
endinterface : pcs_mem_if
`default_nettype wire

// file: design/pcs_id_mem.sv
// small memory holding the identification words
`timescale 1ns/100ps
`default_nettype none
module pcs_id_mem #(
    parameter int AW = 2,
    parameter int DW = 12
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // memory port
    pcs_mem_if.slave mem
);
    logic [DW-1:0] store_reg [2**AW];
    logic [DW-1:0] rdata_reg;

    // words erase to ones, written only in program mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2**AW; i++) begin
                store_reg[i] <= pcs_pkg::ID_RST;
            end
        end else if (mem.we) begin
            store_reg[mem.addr] <= mem.wdata;
        end
    end

    // registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= store_reg[mem.addr];
        end
    end

    assign mem.rdata = rdata_reg;
endmodule : pcs_id_mem
`default_nettype wire

// file: design/pcs_drt.sv
// reset-delay timer: holds core reset for the nominal delay
`timescale 1ns/100ps
`default_nettype none
module pcs_drt #(
    parameter int CYCLES = pcs_pkg::DRT_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // trigger and hold
    input wire logic start_i,
    output logic busy_o
);
    logic [31:0] cnt_reg;

    // elaboration check on the delay length
    if (CYCLES < 1) begin : g_bad_cycles
        $error("drt length must be at least one cycle");
    end

    // counts down from the trigger, busy while nonzero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else if (start_i) begin
            cnt_reg <= 32'(CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 32'd1;
        end
    end

    assign busy_o = (cnt_reg != '0);
endmodule : pcs_drt
`default_nettype wire

// file: design/pcs_core.sv
// pc sequencer and sleep control core with wishbone registers
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module pcs_core #(
    parameter int PC_W = 9,
    parameter int IO_W = 8,
    parameter int DRT_CYCLES = pcs_pkg::DRT_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // instruction decoder
    input wire logic [2:0] op_i,
    input wire logic [8:0] jump_field_i,
    input wire logic [7:0] result_i,
    // master clear pin and watchdog
    input wire logic mclr_n_i,
    input wire logic wdt_timeout_i,
    output logic wdt_clear_o,
    // pin control held in power-down
    input wire logic [IO_W-1:0] io_out_i,
    input wire logic [IO_W-1:0] io_oe_n_i,
    output logic [IO_W-1:0] io_out_o,
    output logic [IO_W-1:0] io_oe_n_o,
    // program readout interface
    input wire logic [11:0] prog_data_i,
    // core status
    output logic [PC_W-1:0] pc_o,
    output logic osc_run_o,
    output logic core_reset_o,
    output logic mclr_drive_n_o
);
    // elaboration check on the pointer width
    if (PC_W < 9 || PC_W > 11) begin : g_bad_pc_w
        $error("pointer width must be 9, 10 or 11");
    end

    // bytes of a 32-bit write that reach the low byte
    function automatic logic [7:0] wb_byte0(input logic [31:0] d, input logic [3:0] s,
                                            input logic [7:0] old);
        wb_byte0 = s[0] ? d[7:0] : old;
    endfunction : wb_byte0

    // page bits into the upper pointer, width dependent
    function automatic logic [PC_W-1:0] with_page(input logic [8:0] low9,
                                                  input logic [7:0] flags);
        logic [10:0] full;
        full = {flags[pcs_pkg::FLG_PAGE_HI], flags[pcs_pkg::FLG_PAGE_LO], low9};
        with_page = full[PC_W-1:0];
    endfunction : with_page

    logic [PC_W-1:0] pc_reg;
    logic [7:0] flags_reg;
    logic [7:0] ctrl_reg;
    logic asleep_reg;
    logic wb_ack_reg;
    logic [31:0] wb_dat_reg;
    logic wdt_clear_reg;
    logic osc_run_reg;
    logic core_reset_reg;
    logic [IO_W-1:0] io_out_reg;
    logic [IO_W-1:0] io_oe_n_reg;
    logic drt_busy;
    logic wdt_wake;
    logic mclr_evt;
    logic wb_req;
    logic wb_wr;
    logic pcl_sw_wr;
    logic in_reset;

    pcs_mem_if #(.AW(2), .DW(12)) id_bus ();

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;
    assign wb_wr = wb_req && wb_we_i;
    assign pcl_sw_wr = wb_wr && (wb_adr_i == pcs_pkg::ADDR_PC_LOW);
    // enabled watchdog expiry, external clear pin
    assign wdt_wake = wdt_timeout_i && ctrl_reg[pcs_pkg::CTL_WDT_EN_BIT];
    assign mclr_evt = !mclr_n_i;
    assign in_reset = drt_busy || mclr_evt;

    // reset-delay timer fired by watchdog time-out or while the clear pin is held low
    pcs_drt #(.CYCLES(DRT_CYCLES)) u_drt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(wdt_wake || mclr_evt),
        .busy_o(drt_busy)
    );

    pcs_id_mem #(.AW(2), .DW(12)) u_id (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mem(id_bus.slave)
    );

    // id words reachable only in program/verify mode
    assign id_bus.we = wb_wr && ctrl_reg[pcs_pkg::CTL_PROG_BIT]
                       && (wb_adr_i[7:4] == pcs_pkg::ADDR_ID_BASE[7:4]);
    assign id_bus.addr = wb_adr_i[3:2];
    assign id_bus.wdata = wb_dat_i[11:0];

    // program pointer sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i || in_reset) begin
            pc_reg <= '1;
        end else if (pcl_sw_wr) begin
            pc_reg <= with_page({1'b0, wb_byte0(wb_dat_i, wb_sel_i, pc_reg[7:0])},
                                flags_reg);
        end else if (!asleep_reg) begin
            case (op_i)
                pcs_pkg::PCS_OP_JUMP: pc_reg <= with_page(jump_field_i, flags_reg);
                pcs_pkg::PCS_OP_CALL,
                pcs_pkg::PCS_OP_PCL_WRITE: pc_reg <= with_page({1'b0, result_i},
                                                              flags_reg);
                pcs_pkg::PCS_OP_SLEEP: pc_reg <= pc_reg + PC_W'(1);
                default: pc_reg <= pc_reg + PC_W'(1);
            endcase
        end
    end

    // sleep state: entered only by the sleep op, left by reset events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            asleep_reg <= 1'b0;
        end else if (mclr_evt || wdt_wake) begin
            asleep_reg <= 1'b0;
        end else if (!in_reset && op_i == pcs_pkg::PCS_OP_SLEEP) begin
            asleep_reg <= 1'b1;
        end
    end

    // flags: page bits by software, to/pd by hardware events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= pcs_pkg::FLAGS_RST;
        end else begin
            if (wb_wr && wb_adr_i == pcs_pkg::ADDR_FLAGS && wb_sel_i[0]) begin
                flags_reg[pcs_pkg::FLG_PAGE_HI:pcs_pkg::FLG_PAGE_LO] <=
                    wb_dat_i[pcs_pkg::FLG_PAGE_HI:pcs_pkg::FLG_PAGE_LO];
                flags_reg[7] <= wb_dat_i[7];
                flags_reg[2:0] <= wb_dat_i[2:0];
            end
            if (wdt_wake) begin
                flags_reg[pcs_pkg::FLG_TO_BIT] <= 1'b0;
            end else if (!in_reset && !asleep_reg && op_i == pcs_pkg::PCS_OP_SLEEP) begin
                flags_reg[pcs_pkg::FLG_TO_BIT] <= 1'b1;
                flags_reg[pcs_pkg::FLG_PD_BIT] <= 1'b0;
            end
        end
    end

    // watchdog clear pulse on sleep and on every wake-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clear_reg <= 1'b0;
        end else begin
            wdt_clear_reg <= (!in_reset && !asleep_reg && op_i == pcs_pkg::PCS_OP_SLEEP)
                             || (!in_reset && !asleep_reg && op_i == pcs_pkg::PCS_OP_CLRWDT)
                             || (asleep_reg && (mclr_evt || wdt_wake));
        end
    end

    // oscillator driver off while asleep; core reset from timer or pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_run_reg <= 1'b1;
            core_reset_reg <= 1'b1;
        end else begin
            osc_run_reg <= !(asleep_reg || (!in_reset && op_i == pcs_pkg::PCS_OP_SLEEP));
            core_reset_reg <= in_reset;
        end
    end

    // pin state frozen during power-down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_out_reg <= '0;
            io_oe_n_reg <= '1;
        end else if (!asleep_reg) begin
            io_out_reg <= io_out_i;
            io_oe_n_reg <= io_oe_n_i;
        end
    end

    // control register written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= pcs_pkg::CTRL_RST;
        end else if (wb_wr && wb_adr_i == pcs_pkg::ADDR_CTRL && wb_sel_i[0]) begin
            ctrl_reg <= wb_dat_i[7:0];
        end
    end

    // wishbone ack: one cycle after the request, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
        end else begin
            wb_ack_reg <= wb_req;
        end
    end

    // read data mux, registered with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_reg <= '0;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                pcs_pkg::ADDR_PC_LOW: wb_dat_reg <= {24'h000000, pc_reg[7:0]};
                pcs_pkg::ADDR_FLAGS: wb_dat_reg <= {24'h000000, flags_reg};
                pcs_pkg::ADDR_CTRL: wb_dat_reg <= {24'h000000, ctrl_reg};
                pcs_pkg::ADDR_STAT: wb_dat_reg <= {28'h0000000, drt_busy, osc_run_reg,
                                                   core_reset_reg, asleep_reg};
                pcs_pkg::ADDR_PC_FULL: wb_dat_reg <= {{(32-PC_W){1'b0}}, pc_reg};
                pcs_pkg::ADDR_PROG_BASE: begin
                    if (ctrl_reg[pcs_pkg::CTL_PROG_BIT] && !ctrl_reg[pcs_pkg::CTL_CP_BIT]) begin
                        wb_dat_reg <= {20'h00000, prog_data_i};
                    end else begin
                        wb_dat_reg <= '0;
                    end
                end
                default: wb_dat_reg <= '0;
            endcase
        end
    end

    // id read data arrives registered; ack timing matches
    logic id_rd_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            id_rd_reg <= 1'b0;
        end else begin
            id_rd_reg <= wb_req && !wb_we_i && ctrl_reg[pcs_pkg::CTL_PROG_BIT]
                         && (wb_adr_i[7:4] == pcs_pkg::ADDR_ID_BASE[7:4]);
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = id_rd_reg ? {20'h00000, id_bus.rdata} : wb_dat_reg;
    assign wdt_clear_o = wdt_clear_reg;
    assign pc_o = pc_reg;
    assign osc_run_o = osc_run_reg;
    assign core_reset_o = core_reset_reg;
    assign mclr_drive_n_o = 1'b1;
    assign io_out_o = io_out_reg;
    assign io_oe_n_o = io_oe_n_reg;
endmodule : pcs_core
`default_nettype wire

// file: dv/pcs_core_checker.sv
// checker: port-level properties of the pc sequencer and sleep control
`timescale 1ns/100ps
`default_nettype none
module pcs_core_checker #(
    parameter int PC_W = 9,
    parameter int IO_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic [2:0] op_i,
    input wire logic [8:0] jump_field_i,
    input wire logic [7:0] result_i,
    input wire logic mclr_n_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_clear_o,
    input wire logic [IO_W-1:0] io_out_o,
    input wire logic [IO_W-1:0] io_oe_n_o,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic osc_run_o,
    input wire logic core_reset_o,
    input wire logic mclr_drive_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // core running with nothing else touching the pointer
    sequence run_s;
        osc_run_o && !core_reset_o && mclr_n_i && !wdt_timeout_i && !(wb_cyc_i && wb_stb_i && wb_we_i);
    endsequence
    AST_PC_INC: assert property (run_s and (op_i == 3'h0) |=> pc_o == $past(pc_o) + 1'b1)
        else $error("pointer did not step by one");
    AST_JUMP: assert property (run_s and (op_i == 3'h1) |=> pc_o[8:0] == $past(jump_field_i))
        else $error("jump field not loaded");
    AST_CALL: assert property (run_s and (op_i == 3'h2) |=> pc_o[8:0] == {1'b0, $past(result_i)})
        else $error("call load wrong");
    AST_SLEEP: assert property (run_s and (op_i == 3'h4) |=> !osc_run_o && wdt_clear_o)
        else $error("sleep entry wrong");
    AST_SLEEP_ONLY: assert property ($fell(osc_run_o) |-> $past(op_i) == 3'h4)
        else $error("power-down without sleep");
    AST_IO_HOLD: assert property (!osc_run_o ##1 !osc_run_o |-> $stable(io_out_o) && $stable(io_oe_n_o))
        else $error("pins moved while asleep");
    AST_MCLR_FREE: assert property (mclr_drive_n_o)
        else $error("master clear pin driven");
    AST_WAKE_CLR: assert property (!osc_run_o && $fell(mclr_n_i) |=> core_reset_o && wdt_clear_o)
        else $error("pin wake wrong");
    AST_DRT_HOLD: assert property ($rose(core_reset_o) && mclr_n_i |-> core_reset_o [*8])
        else $error("reset delay too short");
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer timing wrong");
    // main scenarios
    COV_SLEEP: cover property ($fell(osc_run_o));
    COV_WDT_WAKE: cover property (!osc_run_o && wdt_timeout_i);
    COV_ACK: cover property (wb_ack_o && wb_we_i);
endmodule : pcs_core_checker
bind pcs_core pcs_core_checker #(.PC_W(PC_W), .IO_W(IO_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .op_i(op_i), .jump_field_i(jump_field_i), .result_i(result_i),
    .mclr_n_i(mclr_n_i), .wdt_timeout_i(wdt_timeout_i), .wdt_clear_o(wdt_clear_o),
    .io_out_o(io_out_o), .io_oe_n_o(io_oe_n_o), .pc_o(pc_o), .osc_run_o(osc_run_o),
    .core_reset_o(core_reset_o), .mclr_drive_n_o(mclr_drive_n_o));
`default_nettype wire

// file: dv/pcs_wdt_model.sv
// partner: watchdog counter beside the core
`timescale 1ns/100ps
`default_nettype none
module pcs_wdt_model #(
    parameter int PERIOD = 30
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control and expiry
    input wire logic en_i,
    input wire logic clear_i,
    output logic timeout_o
);
    int cnt;
    // counts while enabled, restarts on clear, pulses on expiry
    always_ff @(posedge clk_i) begin
        timeout_o <= 1'b0;
        if (rst_i || clear_i || !en_i) begin
            cnt <= 0;
        end else if (cnt == PERIOD - 1) begin
            cnt <= 0;
            timeout_o <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : pcs_wdt_model
`default_nettype wire

// file: dv/tb_top.sv
// testbench: bus and decoder sequences against the core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int DRT = 20;
    logic clk_i, rst_i, cyc, stb, we, ack, mclr_n, wdt_to, wdt_clr, wdt_en, osc, crst, mdrv;
    logic [7:0] adr, res, io_out, io_oe, io_q, oe_q;
    logic [31:0] dat, rdat, q;
    logic [2:0] op;
    logic [8:0] jf;
    logic [10:0] pc;
    logic [11:0] pdat;
    int n_errors = 0;
    int n_compared = 0;
    int n;
    // device under test and watchdog partner
    pcs_core #(.PC_W(11), .IO_W(8), .DRT_CYCLES(DRT)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .op_i(op), .jump_field_i(jf),
        .result_i(res), .mclr_n_i(mclr_n), .wdt_timeout_i(wdt_to), .wdt_clear_o(wdt_clr),
        .io_out_i(io_out), .io_oe_n_i(io_oe), .io_out_o(io_q), .io_oe_n_o(oe_q),
        .prog_data_i(pdat), .pc_o(pc), .osc_run_o(osc), .core_reset_o(crst),
        .mclr_drive_n_o(mdrv));
    pcs_wdt_model #(.PERIOD(30)) u_wdt (.clk_i(clk_i), .rst_i(rst_i), .en_i(wdt_en),
        .clear_i(wdt_clr), .timeout_o(wdt_to));
    // clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // verdict and end of run
    task automatic wrap_up();
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic wishbone cycle, read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        #1;
        if (k >= 50) begin
            n_errors++;
            wrap_up();
        end
    endtask : wb
    // one decoded instruction for one cycle
    task automatic do_op(input logic [2:0] o, input logic [8:0] f, input logic [7:0] r);
        @(posedge clk_i);
        op <= o;
        jf <= f;
        res <= r;
        @(posedge clk_i);
        op <= 3'h0;
        #1;
    endtask : do_op
    // wait for wake reset, then count its length
    task automatic wake();
        int k;
        k = 0;
        while (crst !== 1'b1 && k < 200) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        wdt_en <= 1'b0;
        n = 0;
        while (crst === 1'b1 && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        #1;
        if (k >= 200 || n >= 200) begin
            n_errors++;
            wrap_up();
        end
    endtask : wake
    // main sequence
    initial begin
        {cyc, stb, we, wdt_en, op, jf, res, adr, dat} = '0;
        {rst_i, mclr_n} = 2'b11;
        io_out = 8'ha5;
        io_oe = 8'h0f;
        pdat = 12'h9c3;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, pcs_pkg::ADDR_FLAGS, 32'h0);
        chk(q[7:0], 8'h18);
        wb(1'b1, pcs_pkg::ADDR_FLAGS, 32'h60);
        do_op(3'h1, 9'h155, 8'h00);
        chk(pc, 11'h755);
        do_op(3'h2, 9'h000, 8'hab);
        chk(pc, 11'h6ab);
        do_op(3'h3, 9'h000, 8'h5a);
        chk(pc, 11'h65a);
        wb(1'b1, pcs_pkg::ADDR_PC_LOW, 32'h33);
        chk(pc[10:4], 7'h63);
        for (int i = 0; i < 6; i++) begin
            if (i != 4) begin
                do_op(3'(i), 9'h010, 8'h10);
                chk(osc, 1'b1);
            end
        end
        wb(1'b1, pcs_pkg::ADDR_CTRL, 32'h1);
        wdt_en <= 1'b1;
        do_op(3'h4, 9'h0, 8'h0);
        chk(osc, 1'b0);
        wb(1'b0, pcs_pkg::ADDR_FLAGS, 32'h0);
        chk(q[4:3], 2'b10);
        io_out <= 8'h5a;
        io_oe <= 8'hf0;
        repeat (2) @(posedge clk_i);
        #1;
        chk({oe_q, io_q}, 16'h0fa5);
        chk(mdrv, 1'b1);
        wake();
        chk(n >= DRT - 1, 1'b1);
        wb(1'b0, pcs_pkg::ADDR_FLAGS, 32'h0);
        chk(q[4:3], 2'b00);
        wb(1'b1, pcs_pkg::ADDR_CTRL, 32'h0);
        do_op(3'h4, 9'h0, 8'h0);
        mclr_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        mclr_n <= 1'b1;
        wake();
        chk(osc, 1'b1);
        wb(1'b0, pcs_pkg::ADDR_FLAGS, 32'h0);
        chk(q[4:3], 2'b10);
        wb(1'b1, pcs_pkg::ADDR_ID_BASE, 32'hff5);
        wb(1'b0, pcs_pkg::ADDR_ID_BASE, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, pcs_pkg::ADDR_CTRL, 32'h4);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, pcs_pkg::ADDR_ID_BASE + 8'(4 * i), 32'hff0 | i);
        end
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, pcs_pkg::ADDR_ID_BASE + 8'(4 * i), 32'h0);
            chk(q, 32'hff0 | i);
        end
        wb(1'b0, pcs_pkg::ADDR_PROG_BASE, 32'h0);
        chk(q, 32'h9c3);
        wb(1'b1, pcs_pkg::ADDR_CTRL, 32'h6);
        wb(1'b0, pcs_pkg::ADDR_PROG_BASE, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
